/* include/i2c_host_map.svh */
// Register offsets, field positions and timing counts of the two-wire host controller.
`ifndef I2C_HOST_MAP_SVH
`define I2C_HOST_MAP_SVH

// ************************************************
// Register map (byte addresses, one word each)
// ************************************************
`define I2CH_CTRL_OFS 5'h00
`define I2CH_TARGET_OFS 5'h04
`define I2CH_WDATA_OFS 5'h08
`define I2CH_RDATA_OFS 5'h0C
`define I2CH_STATUS_OFS 5'h10

// ************************************************
// Field positions
// ************************************************
`define I2CH_CTRL_GO_BIT 0
`define I2CH_CTRL_READ_BIT 1
`define I2CH_CTRL_SKIP_PTR_BIT 2
`define I2CH_CTRL_COUNT_LSB 4
`define I2CH_STAT_BUSY_BIT 0
`define I2CH_STAT_DONE_BIT 1
`define I2CH_STAT_NACK_BIT 2
`define I2CH_STAT_BAD_BIT 3
`define I2CH_TARGET_PTR_LSB 8

// ************************************************
// Reset values
// ************************************************
`define I2CH_TARGET_RST 7'h48
`define I2CH_PTR_RST 8'h00

// ************************************************
// Timing
// ************************************************
`define I2CH_CLK_PERIOD_NS 4
`define I2CH_QUARTER_NS 700
`define I2CH_QUARTER_CYC ((`I2CH_QUARTER_NS + `I2CH_CLK_PERIOD_NS - 1) / `I2CH_CLK_PERIOD_NS)

`endif

/* include/i2c_host_pkg.sv */
// Types shared by the two-wire host controller.
package i2c_host_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FREE  = 3'h1,
        ST_START = 3'h2,
        ST_BYTE  = 3'h3,
        ST_STOP  = 3'h4
    } state_type;

    typedef enum logic [2:0] {
        STG_ADDR_W = 3'h0,
        STG_PTR    = 3'h1,
        STG_WDATA  = 3'h2,
        STG_ADDR_R = 3'h3,
        STG_RDATA  = 3'h4
    } stage_type;

endpackage

/* logic/i2c_host_ctrl.sv */
// Two-wire bus host that reads and writes a temperature sensor, steered over Wishbone.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "i2c_host_map.svh"

// Overview of operation
// - Host waits for idle bus first.
// - Host clocks nine pulses per byte.
// - Data changes only while clock low.
// - Transaction opens with start condition.
// - Read after pointer uses repeated start.
// - Transaction ends with stop condition.
// - Direction bit: low write, high read.
// - Host releases data in device acknowledge.
// - Host acknowledges first of two bytes.
// - Final read byte gets no acknowledge.
// - Host drives write bits, not acknowledges.
// - Host releases data during read bits.
module i2c_host_ctrl
    import i2c_host_pkg::*;
#(
    parameter int QUARTER_CYC = `I2CH_QUARTER_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Open-drain bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    if (QUARTER_CYC < 2 || QUARTER_CYC > 65535) begin : g_chk
        $error("QUARTER_CYC out of range");
    end

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    localparam logic [15:0] QLOAD = 16'(QUARTER_CYC - 1);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // ************************************************
    // State
    // ************************************************
    state_type st_q, st_d;
    stage_type stg_q, stg_d;
    logic [1:0] q_q, q_d;
    logic [15:0] qcnt_q, qcnt_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] left_q, left_d;
    logic rep_q, rep_d;
    logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic [6:0] target_q, target_d;
    logic [7:0] ptr_q, ptr_d;
    logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic rd_q, rd_d, skip_q, skip_d;
    logic [1:0] count_q, count_d;
    logic done_q, done_d, nack_q, nack_d, bad_q, bad_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;

    logic tick, rx, access, wr, go, go_ok;
    logic [1:0] wcount;

    always_comb begin
        access = wb_cyc_i && wb_stb_i && !ack_q;
        wr = access && wb_we_i;
        tick = (qcnt_q == 16'h0000);
        rx = (stg_q == STG_RDATA);
        go = wr && (wb_adr_i == `I2CH_CTRL_OFS) && wb_sel_i[0] && wb_dat_i[`I2CH_CTRL_GO_BIT];
        wcount = wb_dat_i[`I2CH_CTRL_COUNT_LSB +: 2];
        go_ok = (wcount != 2'h3) && !(wb_dat_i[`I2CH_CTRL_READ_BIT] && wcount == 2'h0);

        st_d = st_q;
        stg_d = stg_q;
        q_d = q_q;
        qcnt_d = qcnt_q;
        sh_d = sh_q;
        bit_d = bit_q;
        left_d = left_q;
        rep_d = rep_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        target_d = target_q;
        ptr_d = ptr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rd_d = rd_q;
        skip_d = skip_q;
        count_d = count_q;
        done_d = done_q;
        nack_d = nack_q;
        bad_d = bad_q;
        ack_d = access;
        dat_d = dat_q;

        // Register reads; unmapped words read as zero and are still acknowledged.
        if (access) begin
            case (wb_adr_i)
                `I2CH_CTRL_OFS: dat_d = {26'h0, count_q, 1'b0, skip_q, rd_q, 1'b0};
                `I2CH_TARGET_OFS: dat_d = {16'h0, ptr_q, 1'b0, target_q};
                `I2CH_WDATA_OFS: dat_d = {16'h0, wdata_q};
                `I2CH_RDATA_OFS: dat_d = {16'h0, rdata_q};
                `I2CH_STATUS_OFS: dat_d = {28'h0, bad_q, nack_q, done_q, st_q != ST_IDLE};
                default: dat_d = 32'h0;
            endcase
        end

        // Quarter-period timer that paces every bus phase.
        if (st_q != ST_IDLE) begin
            if (tick) begin
                qcnt_d = QLOAD;
                q_d = q_q + 2'h1;
            end else begin
                qcnt_d = qcnt_q - 16'h0001;
            end
        end

        case (st_q)
            ST_IDLE: begin
                qcnt_d = QLOAD;
                q_d = 2'h0;
                // Settings are refused while a transfer runs.
                if (wr && wb_adr_i == `I2CH_TARGET_OFS) begin
                    ptr_d = wb_sel_i[1] ? wb_dat_i[15:8] : ptr_q;
                    target_d = wb_sel_i[0] ? wb_dat_i[6:0] : target_q;
                end
                if (wr && wb_adr_i == `I2CH_WDATA_OFS) begin
                    wdata_d = merge16(wdata_q, wb_dat_i, wb_sel_i);
                end
                if (wr && wb_adr_i == `I2CH_CTRL_OFS && wb_sel_i[0]) begin
                    rd_d = wb_dat_i[`I2CH_CTRL_READ_BIT];
                    skip_d = wb_dat_i[`I2CH_CTRL_SKIP_PTR_BIT];
                    count_d = wcount;
                end
                if (go) begin
                    bad_d = !go_ok;
                    if (go_ok) begin
                        st_d = ST_FREE;
                        done_d = 1'b0;
                        nack_d = 1'b0;
                        rdata_d = 16'h0000;
                        rep_d = 1'b0;
                        left_d = wcount;
                        if (wb_dat_i[`I2CH_CTRL_READ_BIT] && wb_dat_i[`I2CH_CTRL_SKIP_PTR_BIT]) begin
                            stg_d = STG_ADDR_R;
                            sh_d = {target_d, 1'b1};
                        end else begin
                            stg_d = STG_ADDR_W;
                            sh_d = {target_d, 1'b0};
                        end
                    end
                end
            end
            ST_FREE: begin
                // Both lines must stay high for a whole quarter before a start is made.
                if (!(scl_s_q && sda_s_q)) begin
                    qcnt_d = QLOAD;
                    q_d = 2'h0;
                end else if (tick) begin
                    st_d = ST_START;
                    q_d = 2'h0;
                end
            end
            ST_START: begin
                // Repeated start first lowers the clock so the data line may rise safely.
                case (q_q)
                    2'h0: scl_oe_d = rep_q;
                    2'h1: sda_oe_d = 1'b0;
                    2'h2: scl_oe_d = 1'b0;
                    default: sda_oe_d = 1'b1;
                endcase
                if (tick && q_q == 2'h3) begin
                    st_d = ST_BYTE;
                    bit_d = 4'h0;
                end
            end
            ST_BYTE: begin
                case (q_q)
                    2'h0: scl_oe_d = 1'b1;
                    2'h1: begin
                        // Data is only changed a quarter after the clock fell.
                        if (bit_q == 4'h8) begin
                            sda_oe_d = rx && (left_q != 2'h1);
                        end else begin
                            sda_oe_d = !rx && !sh_q[7];
                        end
                    end
                    default: scl_oe_d = 1'b0;
                endcase
                if (tick && q_q == 2'h3) begin
                    if (bit_q != 4'h8) begin
                        sh_d = {sh_q[6:0], rx ? sda_s_q : 1'b0};
                        bit_d = bit_q + 4'h1;
                    end else begin
                        bit_d = 4'h0;
                        if (rx) begin
                            rdata_d = {rdata_q[7:0], sh_q};
                            left_d = left_q - 2'h1;
                            if (left_q == 2'h1) begin
                                st_d = ST_STOP;
                            end
                        end else if (sda_s_q) begin
                            nack_d = 1'b1;
                            st_d = ST_STOP;
                        end else begin
                            case (stg_q)
                                STG_ADDR_W: begin
                                    stg_d = STG_PTR;
                                    sh_d = ptr_q;
                                end
                                STG_PTR: begin
                                    if (rd_q) begin
                                        st_d = ST_START;
                                        q_d = 2'h0;
                                        rep_d = 1'b1;
                                        stg_d = STG_ADDR_R;
                                        sh_d = {target_q, 1'b1};
                                    end else if (left_q == 2'h0) begin
                                        st_d = ST_STOP;
                                    end else begin
                                        stg_d = STG_WDATA;
                                        sh_d = (left_q == 2'h2) ? wdata_q[15:8] : wdata_q[7:0];
                                    end
                                end
                                STG_WDATA: begin
                                    left_d = left_q - 2'h1;
                                    sh_d = wdata_q[7:0];
                                    if (left_q == 2'h1) begin
                                        st_d = ST_STOP;
                                    end
                                end
                                STG_ADDR_R: stg_d = STG_RDATA;
                                default: st_d = ST_STOP;
                            endcase
                        end
                    end
                end
            end
            ST_STOP: begin
                case (q_q)
                    2'h0: scl_oe_d = 1'b1;
                    2'h1: sda_oe_d = 1'b1;
                    2'h2: scl_oe_d = 1'b0;
                    default: sda_oe_d = 1'b0;
                endcase
                if (tick && q_q == 2'h3) begin
                    st_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            stg_q <= STG_ADDR_W;
            q_q <= 2'h0;
            qcnt_q <= 16'h0000;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            left_q <= 2'h0;
            rep_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            target_q <= `I2CH_TARGET_RST;
            ptr_q <= `I2CH_PTR_RST;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            rd_q <= 1'b0;
            skip_q <= 1'b0;
            count_q <= 2'h0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            bad_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            stg_q <= stg_d;
            q_q <= q_d;
            qcnt_q <= qcnt_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            left_q <= left_d;
            rep_q <= rep_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            target_q <= target_d;
            ptr_q <= ptr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rd_q <= rd_d;
            skip_q <= skip_d;
            count_q <= count_d;
            done_q <= done_d;
            nack_q <= nack_d;
            bad_q <= bad_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    // The pins are open drain, so the driven level is always low.
    logic low_q;

    always_ff @(posedge clk_i) begin
        low_q <= 1'b0;
    end

    always_comb begin
        wb_dat_o = dat_q;
        wb_ack_o = ack_q;
        scl_o = low_q;
        scl_oe_o = scl_oe_q;
        sda_o = low_q;
        sda_oe_o = sda_oe_q;
    end

endmodule

/* dv/i2c_host_props.sv */
// Checker of the two-wire host controller ports.
`timescale 1ns/1ps
module i2c_host_props #(
    parameter int QUARTER_CYC = 175
) (
    // Clock, reset and Wishbone
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Bus pins
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    localparam int QW = QUARTER_CYC + 2;
    logic [3:0] bit_q;
    logic first_q, rwc_q, rd_q, last_q;

    // ****************
    // Bit position tracker
    // ****************
    // Simpler to track with sampled functions in one clocked process than to split it.
    always_ff @(posedge clk_i) begin
        if (rst_i || ($rose(sda_oe_o) && !scl_oe_o)) begin
            bit_q <= 4'hF;
            first_q <= 1'b1;
            rd_q <= 1'b0;
            last_q <= 1'b0;
        end else if ($rose(scl_oe_o)) begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h7 && first_q) rwc_q <= !sda_oe_o;
            if (bit_q == 4'h8) first_q <= 1'b0;
            if (bit_q == 4'h8 && first_q) rd_q <= rwc_q;
            if (bit_q == 4'h8 && rd_q && !sda_oe_o) last_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_start; $rose(sda_oe_o) && !scl_oe_o; endsequence
    sequence s_stop; $fell(sda_oe_o) && !scl_oe_o; endsequence

    a_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_open_drain: assert property (!scl_o && !sda_o) else $error("pin driven high");
    a_free_start: assert property (s_start |-> $past(scl_i && sda_i)) else $error("busy bus");
    a_start_hold: assert property (s_start |-> sda_oe_o throughout (##[1:QW] $rose(scl_oe_o)))
        else $error("bad start");
    a_stop_free: assert property (s_stop |=> (!scl_oe_o && !sda_oe_o) [*3]) else $error("bad stop");
    a_sda_setup: assert property ($fell(scl_oe_o) |-> $stable(sda_oe_o) [*3]) else $error("data moved");
    a_ack_release: assert property (!scl_oe_o && bit_q == 4'h8 && !rd_q |-> !sda_oe_o)
        else $error("ack slot held");
    a_read_release: assert property (!scl_oe_o && rd_q && !last_q && bit_q < 4'h8 |-> !sda_oe_o)
        else $error("read bit held");
endmodule

bind i2c_host_ctrl i2c_host_props #(.QUARTER_CYC(QUARTER_CYC)) i_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

/* dv/temp_sensor_model.sv */
// Behavioural sensor target on the two-wire bus, with power-up defaults.
`timescale 1ns/1ps
module temp_sensor_model #(
    // Fixed bits joined with the select pins; the value is a plain default.
    parameter logic [6:0] DEV_ADDR = 7'h48
) (
    // Bus lines and supply monitor
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic supply_ok_i,
    output logic sda_oe_o
);
    logic [15:0] word_q [4];
    logic [7:0] sh_q;
    logic [1:0] ptr_q;
    logic act_q, rd_q;
    int bits_q, phase_q, idx_q;

    task automatic load_defaults();
        word_q[0] = 16'h00C8 << 5;
        word_q[1] = 16'h0000;
        word_q[2] = 16'h0096 << 7;
        word_q[3] = 16'h00A0 << 7;
        ptr_q = 2'h0;
        act_q = 1'b0;
        sda_oe_o = 1'b0;
    endtask

    initial load_defaults();
    always @(posedge supply_ok_i) load_defaults();
    always @(negedge sda_i) if (scl_i && supply_ok_i) begin
        act_q = 1'b1;
        bits_q = 0;
        phase_q = 0;
    end
    always @(posedge sda_i) if (scl_i) begin
        act_q = 1'b0;
        sda_oe_o = 1'b0;
    end
    always @(posedge scl_i) if (act_q) begin
        if (bits_q == 8 && phase_q == 3 && sda_i) act_q = 1'b0;
        sh_q = {sh_q[6:0], sda_i};
        bits_q++;
    end
    // Only moves the data line while the clock is low.
    always @(negedge scl_i) if (act_q) begin
        if (bits_q == 8 && phase_q != 3) begin
            sda_oe_o = 1'b1;
            if (phase_q == 0 && sh_q[7:1] != DEV_ADDR) begin
                act_q = 1'b0;
                sda_oe_o = 1'b0;
            end
            if (phase_q == 0) rd_q = sh_q[0];
            if (phase_q == 1) ptr_q = sh_q[1:0];
            if (phase_q == 2 && ptr_q == 2'h1) word_q[1] = {sh_q, sh_q};
            if (phase_q == 2 && ptr_q[1]) word_q[ptr_q][15 - 8 * (idx_q % 2) -: 8] = sh_q;
        end else if (bits_q == 8) begin
            sda_oe_o = 1'b0;
        end else if (bits_q == 9) begin
            sda_oe_o = 1'b0;
            bits_q = 0;
            idx_q = (phase_q < 2) ? 0 : idx_q + 1;
            phase_q = (phase_q == 0) ? (rd_q ? 3 : 1) : (phase_q == 1 ? 2 : phase_q);
        end
        if (phase_q == 3 && bits_q < 8) sda_oe_o = !word_q[ptr_q][15 - 8 * (idx_q % 2) - bits_q];
    end
endmodule

/* dv/i2c_host_ctrl_tb.sv */
// Self-checking bench of the two-wire host controller against a sensor model.
`timescale 1ns/1ps
`include "i2c_host_map.svh"
module i2c_host_ctrl_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, dev_oe;
    logic supply_ok = 1'b1;
    wire scl = !scl_oe_o;
    wire sda = !(sda_oe_o || dev_oe);
    int err_total = 0;
    int checks = 0;
    int ref_w [4];

    initial forever #2 clk_i = !clk_i;

    i2c_host_ctrl #(.QUARTER_CYC(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
    temp_sensor_model i_dev (.scl_i(scl), .sda_i(sda), .supply_ok_i(supply_ok), .sda_oe_o(dev_oe));

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'h3;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic go(input logic [31:0] c, input logic [31:0] st);
        wb(`I2CH_CTRL_OFS, 1'b1, c);
        wb(`I2CH_STATUS_OFS, 1'b0, 32'h0);
        while (q[0] !== 1'b0) wb(`I2CH_STATUS_OFS, 1'b0, 32'h0);
        chk("status", st, q);
    endtask
    task automatic wr_reg(input logic [7:0] p, input logic [1:0] n, input logic [15:0] d);
        wb(`I2CH_TARGET_OFS, 1'b1, {16'h0, p, 8'h48});
        wb(`I2CH_WDATA_OFS, 1'b1, {16'h0, d});
        go({26'h0, n, 4'h1}, 32'h2);
    endtask
    task automatic rd_all();
        for (int p = 0; p < 4; p++) begin
            wb(`I2CH_TARGET_OFS, 1'b1, {16'h0, 8'(p), 8'h48});
            go({26'h0, (p == 1) ? 2'h1 : 2'h2, 4'h3}, 32'h2);
            wb(`I2CH_RDATA_OFS, 1'b0, 32'h0);
            chk("rdata", ref_w[p], q);
        end
        // The sensor keeps the last pointer, so a read without a pointer returns the upper limit.
        go(32'h27, 32'h2);
        wb(`I2CH_RDATA_OFS, 1'b0, 32'h0);
        chk("skip_read", ref_w[3], q);
    endtask
    task automatic set_ref();
        ref_w[0] = (25 * 8) << 5;
        ref_w[1] = 0;
        ref_w[2] = (75 * 2) << 7;
        ref_w[3] = (80 * 2) << 7;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(36));
        set_ref();
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(`I2CH_TARGET_OFS, 1'b0, 32'h0);
        chk("target", 32'h48, q);
        wb(5'h14, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        go(32'h27, 32'h2);
        wb(`I2CH_RDATA_OFS, 1'b0, 32'h0);
        chk("temp", ref_w[0], q);
        rd_all();
        for (int i = 0; i < 3; i++) begin
            ref_w[1] = $urandom % 32;
            ref_w[2] = ($urandom % 512) << 7;
            ref_w[3] = ($urandom % 512) << 7;
            wr_reg(8'h01, 2'h1, {ref_w[1][7:0], ref_w[1][7:0]});
            wr_reg(8'h02, 2'h2, ref_w[2][15:0]);
            wr_reg(8'h03, 2'h2, ref_w[3][15:0]);
            rd_all();
        end
        wr_reg(8'h00, 2'h0, 16'h0000);
        go(32'h27, 32'h2);
        wb(`I2CH_RDATA_OFS, 1'b0, 32'h0);
        chk("ptr_only", ref_w[0], q);
        supply_ok <= 1'b0;
        repeat (20) @(posedge clk_i);
        supply_ok <= 1'b1;
        set_ref();
        go(32'h27, 32'h2);
        wb(`I2CH_RDATA_OFS, 1'b0, 32'h0);
        chk("dip_ptr", ref_w[0], q);
        rd_all();
        wb(`I2CH_TARGET_OFS, 1'b1, {16'h0, 8'h02, 8'h49});
        go(32'h21, 32'h6);
        wb(`I2CH_CTRL_OFS, 1'b1, 32'h31);
        wb(`I2CH_STATUS_OFS, 1'b0, 32'h0);
        chk("bad", 32'h1, {31'h0, q[3]});
        tally_and_finish();
    end
endmodule
